/* File: design/ctp_pin_sync.sv */
// Module: three-flop synchroniser with falling-edge pulse for the external count pin
module ctp_pin_sync
  import ctp_pkg::*;
(
  // Clock and reset
  input  wire logic mclk,
  input  wire logic rstn,
  // Pin and result
  input  wire logic pinIn,
  output logic      fallPulse
);

  logic s1_r;      // First stage, read only by s2
  logic s2_r;      // Second stage
  logic s3_r;      // Third stage
  logic stable_r;  // Agreed level

  // Shift chain
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      s1_r     <= 1'b1;
      s2_r     <= 1'b1;
      s3_r     <= 1'b1;
      stable_r <= 1'b1;
    end else begin
      s1_r <= pinIn;
      s2_r <= s1_r;
      s3_r <= s2_r;
      if (s2_r == s3_r) begin
        stable_r <= s3_r;
      end
    end
  end

  // Falling edge once stages agree
  assign fallPulse = stable_r & (s2_r == s3_r) & ~s3_r;

endmodule

/* File: design/ctp_pkg.sv */
// Package: register map, field layout, reset values and shared types for the cascaded PWM
package ctp_pkg;

  // Duty register indices; one aligned 32-bit word each
  localparam logic [11:0] CTP_IDX_DUTY_LOW   = 12'h028;  // Index of duty low register
  localparam logic [11:0] CTP_IDX_DUTY_HIGH  = 12'h029;  // Index of duty high register
  // Byte addresses of the registers
  localparam logic [11:0] CTP_ADDR_DUTY_LOW  = CTP_IDX_DUTY_LOW << 2;   // Four times index
  localparam logic [11:0] CTP_ADDR_DUTY_HIGH = CTP_IDX_DUTY_HIGH << 2;  // Four times index
  localparam logic [11:0] CTP_ADDR_MODE      = 12'h02C;  // Byte address of mode register
  localparam logic [11:0] CTP_ADDR_CTRL      = 12'h030;  // Byte address of control register
  localparam logic [11:0] CTP_ADDR_STATUS    = 12'h034;  // Byte address of status register

  // Reset values
  localparam logic [7:0] CTP_RST_DUTY_LOW  = 8'hFF;
  localparam logic [7:0] CTP_RST_DUTY_HIGH = 8'hFF;
  localparam logic [7:0] CTP_RST_MODE      = 8'h00;
  localparam logic [7:0] CTP_RST_CTRL      = 8'h00;

  // Mode register fields
  localparam int CTP_MODE_TFF  = 0;  // Initial level select
  localparam int CTP_MODE_DBE  = 1;  // Buffer enable
  localparam int CTP_MODE_EXT  = 2;  // External count pin select
  localparam int CTP_MODE_TCM  = 3;  // Operating mode, two bits
  localparam logic [1:0] CTP_TCM_PWM = 2'h2;

  // Control register fields
  localparam int CTP_CTRL_RUN  = 0;  // Run bit
  localparam int CTP_CTRL_CAS  = 1;  // Cascade enable

  // Counter limits
  localparam logic [7:0] CTP_CNT_ZERO  = 8'h00;
  localparam logic [3:0] CTP_IDX_FIRST = 4'h1;
  localparam logic [3:0] CTP_IDX_LAST  = 4'h0;  // Cycle 16 wraps to zero

  // Duty pair as stored
  typedef struct packed {
    logic [3:0] extra;  // Extra-pulse select
    logic [7:0] duty;   // Duty compare value
  } ctp_duty_s;

  // Run state: idle or running
  typedef enum logic [1:0] {
    CTP_IDLE = 2'b01,
    CTP_RUN  = 2'b10
  } ctp_state_e;

endpackage

/* File: design/ctp_pwm.sv */
// Module: cascaded 8-bit timer pair in 12-bit PWM mode with APB register access
//
// Implementation choice: register access over APB.
module ctp_pwm
  import ctp_pkg::*;
(
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        rstn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // Source clocks
  input  wire logic        internalTick,
  input  wire logic        externalCountPin,
  // Pin function select and outputs
  input  wire logic        pinFuncEn,
  output logic             pwmOutputPin,
  output logic             periodIrq,
  output logic             frameIrq
);

  logic [7:0] dutyLow_r;     // Low register as written
  logic [7:0] dutyHigh_r;    // High register as written
  logic [7:0] mode_r;        // High timer mode register
  logic [1:0] ctrl_r;        // Run and cascade
  ctp_duty_s  buf_r;         // Double buffer
  ctp_duty_s  eff_r;         // Effective duty value
  logic [7:0] cnt_r;         // Up counter
  logic [3:0] idx_r;         // Frame cycle index
  logic       out_r;         // Output toggle state
  logic       fired_r;       // Duty toggle done this period
  ctp_state_e state_r;       // Idle or running
  logic [7:0] rdata_nxt;     // Read mux
  logic       extFall;       // Synchronised pin edge
  logic       tick;          // Source clock event
  logic       running;       // Counting now
  logic       wrEn;          // Write access phase
  logic       hiWrite;       // Commit of duty pair
  ctp_duty_s  newDuty;       // Value being committed
  logic [7:0] matchVal;      // Compare value this cycle
  logic       stretch;       // Current cycle stretched
  logic       ovf;           // Overflow this tick
  logic       addrOk;        // Mapped address

  // External pin synchroniser
  ctp_pin_sync uSync (
    .mclk      (mclk),
    .rstn      (rstn),
    .pinIn     (externalCountPin),
    .fallPulse (extFall)
  );

  // Cycle selection table for extra pulses
  function automatic logic isStretched(input logic [3:0] sel, input logic [3:0] idx);
    logic hit;
    hit = 1'b0;
    if (sel[0] && idx == 4'h9) hit = 1'b1;
    if (sel[1] && idx[2:0] == 3'h5) hit = 1'b1;
    if (sel[2] && idx[1:0] == 2'h3) hit = 1'b1;
    if (sel[3] && !idx[0]) hit = 1'b1;
    return hit;
  endfunction

  // Bus decode
  assign pready  = 1'b1;
  assign addrOk  = paddr == CTP_ADDR_DUTY_LOW || paddr == CTP_ADDR_DUTY_HIGH ||
                   paddr == CTP_ADDR_MODE || paddr == CTP_ADDR_CTRL ||
                   paddr == CTP_ADDR_STATUS;
  assign pslverr = psel & penable & ~addrOk;
  assign wrEn    = psel & penable & pwrite;
  assign hiWrite = wrEn && paddr == CTP_ADDR_DUTY_HIGH;
  assign newDuty = '{extra: dutyLow_r[3:0], duty: {pwdata[3:0], dutyLow_r[7:4]}};

  // Mode decode and source select
  assign running = state_r == CTP_RUN;
  assign tick    = running & (mode_r[CTP_MODE_EXT] ? extFall : internalTick);
  assign stretch = isStretched(eff_r.extra, idx_r);
  assign matchVal = eff_r.duty + (stretch ? 8'h01 : 8'h00);
  assign ovf     = tick && cnt_r == 8'hFF;

  // Low register and high register storage
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      dutyLow_r  <= CTP_RST_DUTY_LOW;
      dutyHigh_r <= CTP_RST_DUTY_HIGH;
    end else if (wrEn) begin
      if (paddr == CTP_ADDR_DUTY_LOW) dutyLow_r <= pwdata[7:0];
      if (paddr == CTP_ADDR_DUTY_HIGH) dutyHigh_r <= pwdata[7:0];
    end
  end

  // Mode register, locked while running
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      mode_r <= CTP_RST_MODE;
    end else if (wrEn && paddr == CTP_ADDR_MODE && !ctrl_r[CTP_CTRL_RUN]) begin
      mode_r <= pwdata[7:0];
    end
  end

  // Control register
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      ctrl_r <= CTP_RST_CTRL[1:0];
    end else if (wrEn && paddr == CTP_ADDR_CTRL) begin
      ctrl_r <= pwdata[1:0];
    end
  end

  // Run state follows run bit when cascade is enabled and PWM mode is selected
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      state_r <= CTP_IDLE;
    end else if (ctrl_r[CTP_CTRL_RUN] && ctrl_r[CTP_CTRL_CAS] &&
                 mode_r[CTP_MODE_TCM +: 2] == CTP_TCM_PWM) begin
      state_r <= CTP_RUN;
    end else begin
      state_r <= CTP_IDLE;
    end
  end

  // Double buffer and effective duty value
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      buf_r <= '{extra: CTP_RST_DUTY_LOW[3:0], duty: 8'hFF};
      eff_r <= '{extra: CTP_RST_DUTY_LOW[3:0], duty: 8'hFF};
    end else begin
      if (hiWrite) begin
        buf_r <= newDuty;
      end
      if (hiWrite && (!running || !mode_r[CTP_MODE_DBE])) begin
        eff_r <= newDuty;
      end else if (running && mode_r[CTP_MODE_DBE] && ovf && idx_r == CTP_IDX_LAST) begin
        eff_r <= buf_r;
      end
    end
  end

  // Counter, cycle index and output
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      cnt_r   <= CTP_CNT_ZERO;
      idx_r   <= CTP_IDX_FIRST;
      out_r   <= 1'b0;
      fired_r <= 1'b0;
    end else if (!running) begin
      cnt_r   <= CTP_CNT_ZERO;
      idx_r   <= CTP_IDX_FIRST;
      out_r   <= 1'b0;
      fired_r <= 1'b0;
    end else if (ovf) begin
      cnt_r   <= CTP_CNT_ZERO;
      idx_r   <= idx_r + 4'h1;
      out_r   <= 1'b0;
      fired_r <= 1'b0;
    end else begin
      if (tick) cnt_r <= cnt_r + 8'h01;
      if (!fired_r && cnt_r == matchVal && !(stretch && eff_r.duty == 8'hFF)) begin
        out_r   <= 1'b1;
        fired_r <= 1'b1;
      end
    end
  end

  // Interrupt pulses
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      periodIrq <= 1'b0;
      frameIrq  <= 1'b0;
    end else begin
      periodIrq <= running & ovf;
      frameIrq  <= running & ovf & (idx_r == CTP_IDX_LAST);
    end
  end

  // Pin level: idle level xor toggle state, held low while pinFuncEn is off
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      pwmOutputPin <= 1'b0;
    end else begin
      pwmOutputPin <= pinFuncEn & (mode_r[CTP_MODE_TFF] ^ out_r);
    end
  end

  // Read mux; buffered reads show buffer via register copies
  always_comb begin
    rdata_nxt = 8'h00;
    case (paddr)
      CTP_ADDR_DUTY_LOW:  rdata_nxt = dutyLow_r;
      CTP_ADDR_DUTY_HIGH: rdata_nxt = dutyHigh_r;
      CTP_ADDR_MODE:      rdata_nxt = mode_r;
      CTP_ADDR_CTRL:      rdata_nxt = {6'h00, ctrl_r};
      CTP_ADDR_STATUS:    rdata_nxt = {idx_r, 2'h0, running, out_r};
      default:            rdata_nxt = 8'h00;
    endcase
  end
  assign prdata = {24'h000000, rdata_nxt};

  // Overflow interrupt follows each wrap by one cycle
  chk_period_irq: assert property (@(posedge mclk) disable iff (!rstn)
    running && ovf |=> periodIrq) else $error("period irq missing");
  // Counter clears after overflow
  chk_ovf_clear: assert property (@(posedge mclk) disable iff (!rstn)
    running && ovf |=> cnt_r == 8'h00 && !out_r) else $error("overflow not cleared");
  // Frame irq only at index wrap
  chk_frame_irq: assert property (@(posedge mclk) disable iff (!rstn)
    frameIrq |-> $past(idx_r) == 4'h0) else $error("frame irq off frame");
  // Stop restores idle
  chk_stop_idle: assert property (@(posedge mclk) disable iff (!rstn)
    !running |=> cnt_r == 8'h00 && idx_r == 4'h1) else $error("stop not idle");
  // Mode locked while running
  chk_mode_lock: assert property (@(posedge mclk) disable iff (!rstn)
    ctrl_r[0] |=> $stable(mode_r)) else $error("mode changed while running");
  // Buffered running write leaves effective value alone
  chk_buf_hold: assert property (@(posedge mclk) disable iff (!rstn)
    hiWrite && running && mode_r[1] && !ovf |=> $stable(eff_r)) else $error("buffer leaked");
  // Stopped write applies at once
  chk_stop_write: assert property (@(posedge mclk) disable iff (!rstn)
    hiWrite && !running |=> eff_r == $past(newDuty)) else $error("stopped write lost");
  // Output toggles only when count reaches compare
  chk_duty_match: assert property (@(posedge mclk) disable iff (!rstn)
    running && !ovf && $rose(out_r) |-> $past(cnt_r) == $past(matchVal))
    else $error("toggle without match");

endmodule

/* File: tb/ctp_far_side.sv */
// Far-side model: internal source ticks and external count pin
module ctp_far_side #(
  parameter int TICK_DIV = 2  // Core cycles per internal count
) (
  // Clock and reset
  input  wire logic mclk,
  input  wire logic rstn,
  // Pin source control and outputs
  input  wire logic extRun,
  output logic      internalTick,
  output logic      externalCountPin
);
  timeunit 1ns;
  timeprecision 1ns;
  int tickCnt;  // Tick divider
  int extCnt;   // Pin phase counter
  // One-cycle tick every TICK_DIV cycles
  always_ff @(posedge mclk) begin
    tickCnt <= (!rstn || tickCnt == TICK_DIV - 1) ? 0 : tickCnt + 1;
    internalTick <= rstn && tickCnt == TICK_DIV - 1;
  end
  // Pin stands high when idle; four-cycle phases
  always_ff @(posedge mclk) begin
    extCnt <= (!extRun || extCnt == 3) ? 0 : extCnt + 1;
    if (!extRun) begin
      externalCountPin <= 1'b1;
    end else if (extCnt == 3) begin
      externalCountPin <= ~externalCountPin;
    end
  end
endmodule

/* File: tb/test_ctp_pwm.sv */
// Testbench: registers, PWM timing, buffering and source select
`define CHK(nm, e, g) begin nTests++; if ((g) !== (e)) begin nErrors++; \
  $display("MISMATCH %s expected %0h seen %0h", nm, e, g); end end
module test_ctp_pwm;
  import ctp_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int DIV = 2;  // Core cycles per count
  logic        mclk = 0, rstn = 0, psel = 0, penable = 0, pwrite = 0;
  logic        pinFuncEn = 1, extRun = 0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic [31:0] prdata, rd;
  logic        pready, pslverr, tick, extPin, pwmOut, perIrq, frmIrq, err;
  int          nErrors = 0, nTests = 0, cyc = 0, hi, np, c;
  // Clock
  initial forever #25 mclk = ~mclk;
  // Hang guard
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 90000) begin
      nErrors++;
      conclude();
    end
  end
  ctp_pwm dut (.mclk(mclk), .rstn(rstn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .internalTick(tick),
    .externalCountPin(extPin), .pinFuncEn(pinFuncEn), .pwmOutputPin(pwmOut),
    .periodIrq(perIrq), .frameIrq(frmIrq));
  ctp_far_side #(.TICK_DIV(DIV)) far (.mclk(mclk), .rstn(rstn), .extRun(extRun),
    .internalTick(tick), .externalCountPin(extPin));
  // One APB transfer; answer taken at the ready edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do @(posedge mclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  // Read and compare
  task automatic rc(input string nm, input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, '0);
    `CHK(nm, e, rd)
  endtask
  // Low register first, high commits both
  task automatic duty(input logic [7:0] dv, input logic [3:0] ex);
    wr(CTP_ADDR_DUTY_LOW, {24'h0, dv[3:0], ex});
    wr(CTP_ADDR_DUTY_HIGH, {28'h0, dv[7:4]});
  endtask
  // Stop, configure, run with cascade
  task automatic start(input logic [7:0] md, input logic [7:0] dv, input logic [3:0] ex);
    wr(CTP_ADDR_CTRL, 32'h2);
    wr(CTP_ADDR_MODE, {24'h0, md});
    duty(dv, ex);
    wr(CTP_ADDR_CTRL, 32'h3);
  endtask
  task automatic wait_frm();
    do @(negedge mclk); while (frmIrq !== 1'b1);
  endtask
  // Pin high cycles and periods up to the next frame end
  task automatic measure();
    hi = 0;
    np = 0;
    do begin
      @(negedge mclk);
      hi += int'(pwmOut);
      np += int'(perIrq);
    end while (frmIrq !== 1'b1);
  endtask
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", nTests, nErrors);
    if (nErrors == 0 && nTests > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // Main sequence
  initial begin
    repeat (5) @(posedge mclk);
    rstn <= 1'b1;
    rc("duty low", CTP_ADDR_DUTY_LOW, 32'hFF);
    rc("duty high", CTP_ADDR_DUTY_HIGH, 32'hFF);
    rc("mode", CTP_ADDR_MODE, 32'h0);
    rc("ctrl", CTP_ADDR_CTRL, 32'h0);
    apb(1'b0, 12'h03C, '0);
    `CHK("unmapped error", 1'b1, err)
    wr(CTP_ADDR_DUTY_HIGH, 32'hA5);
    rc("upper nibble", CTP_ADDR_DUTY_HIGH, 32'hA5);
    $display("register test done");
    wr(CTP_ADDR_MODE, 32'h11);
    repeat (3) @(negedge mclk);
    `CHK("idle high", 1'b1, pwmOut)
    @(posedge mclk) pinFuncEn <= 1'b0;
    repeat (3) @(negedge mclk);
    `CHK("pin off", 1'b0, pwmOut)
    @(posedge mclk) pinFuncEn <= 1'b1;
    wr(CTP_ADDR_MODE, 32'h10);
    repeat (3) @(negedge mclk);
    `CHK("idle low", 1'b0, pwmOut)
    $display("idle level test done");
    start(8'h10, 8'h40, 4'h3);
    wait_frm();
    measure();
    `CHK("high time", DIV * (16 * 192 - 3) - 16, hi)
    `CHK("periods", 16, np)
    start(8'h11, 8'h80, 4'hC);
    wait_frm();
    measure();
    `CHK("initial phase", DIV * (16 * 128 + 12) + 16, hi)
    wr(CTP_ADDR_CTRL, 32'h2);
    repeat (5) @(negedge mclk);
    `CHK("stopped level", 1'b1, pwmOut)
    $display("duty test done");
    start(8'h12, 8'h30, 4'h0);
    wait_frm();
    duty(8'h50, 4'h1);
    rc("buffer read", CTP_ADDR_DUTY_LOW, 32'h01);
    wr(CTP_ADDR_MODE, 32'h13);
    rc("mode locked", CTP_ADDR_MODE, 32'h12);
    measure();
    `CHK("old duty", DIV * 16 * 208 - 16, hi)
    measure();
    `CHK("new duty", DIV * (16 * 176 - 1) - 16, hi)
    $display("buffer test done");
    start(8'h14, 8'h80, 4'h0);
    @(posedge mclk) extRun <= 1'b1;
    do @(negedge mclk); while (perIrq !== 1'b1);
    c = 0;
    do begin
      @(negedge mclk);
      c++;
    end while (perIrq !== 1'b1);
    `CHK("pin period", 2048, c)
    $display("external source test done");
    conclude();
  end
endmodule
